// ---- design/cdc_defines.vh ----
/*
 Constants for the codec host sequencing block: register offsets, field
 positions, reset values and timing counts. Included by every design file.
*/
`ifndef CDC_DEFINES_VH
`define CDC_DEFINES_VH

// Wishbone byte addresses, one aligned word per register
`define CDC_A_INDEX      6'h00
`define CDC_A_RATEFMT    6'h04
`define CDC_A_CAPFMT     6'h08
`define CDC_A_IFCFG      6'h0c
`define CDC_A_ERRSTAT    6'h10
`define CDC_A_STATUS     6'h14
`define CDC_A_PBASE_LO   6'h18
`define CDC_A_PBASE_HI   6'h1c
`define CDC_A_CBASE_LO   6'h20
`define CDC_A_CBASE_HI   6'h24
`define CDC_A_AFSTAT     6'h28
`define CDC_A_PCOUNT     6'h2c
`define CDC_A_CCOUNT     6'h30
`define CDC_A_MODE       6'h34

// Index register fields
`define CDC_IDX_MCE      6
`define CDC_BUSY_VAL     8'h80
// Format register fields
`define CDC_FMT_CFS_LSB  1
`define CDC_FMT_CFS_MSB  3
`define CDC_FMT_CSL      0
`define CDC_FMT_STEREO   4
`define CDC_FMT_LSB      5
`define CDC_FMT_MSB      7
// Format codes
`define CDC_F_U8         3'h0
`define CDC_F_ULAW       3'h1
`define CDC_F_S16LE      3'h2
`define CDC_F_ALAW       3'h3
`define CDC_F_ADPCM      3'h5
`define CDC_F_S16BE      3'h6
// Interface configuration fields
`define CDC_CFG_PEN      0
`define CDC_CFG_CEN      1
`define CDC_CFG_CALIBRATE_ON_EXIT_BIT     3
`define CDC_CFG_PLAYBACK_PROGRAMMED_IO_SELECT     6
`define CDC_CFG_CAPTURE_PROGRAMMED_IO_SELECT     7
`define CDC_CFG_ENMASK   8'h03
// Error status and flag fields
`define CDC_ERR_ACI      5
`define CDC_STAT_INT     0
`define CDC_AF_PI        4
`define CDC_AF_CI        5
`define CDC_MODE_EXT     6
// Reset values
`define CDC_RST_INDEX    8'h40
`define CDC_RST_FMT      8'h00
`define CDC_RST_CFG      8'h08
// Timing
`define CDC_CAL_PERIODS  9'h0a8
`define CDC_RESYNC_CYC   8'h40
`define CDC_CLK_HZ       40000000
`define CDC_FS_BASE_HZ   8000
`endif

// ---- design/cdc_fs_tick.v ----
/*
 Sample-period tick generator: a divider from the system clock giving one
 enable pulse per sample period for the selected divide code.
 Assumes a single clock; the divide code changes only during mode change.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defines.vh"

module cdc_fs_tick
(
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Rate select
	input  wire [2:0]  div_sel_i,
	// Tick
	output reg         tick_o
);
	localparam integer BASE_DIV_W = `CDC_CLK_HZ / `CDC_FS_BASE_HZ;
	localparam [15:0]  BASE_DIV   = BASE_DIV_W[15:0];

	reg  [15:0] cnt_q;
	wire [15:0] limit;

	// Approximate rates: base divider shifted by the low two bits of the code
	assign limit = BASE_DIV >> div_sel_i[1:0];

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= 16'h0000;
			tick_o <= 1'b0;
		end
		else if (cnt_q >= limit - 16'h0001)
		begin
			cnt_q  <= 16'h0000;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule // cdc_fs_tick
`default_nettype wire

// ---- design/cdc_host_seq.v ----
/*
 Codec host sequencing: mode-change gate, resynchronisation busy window,
 auto calibration, sample byte formatting and DMA sample counters, reached
 over a classic Wishbone slave with 8-bit registers and 16-bit current counts in 32-bit words.
 Assumes one 40 MHz clock and a sample stream interface on the same clock.
*/
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
// Operation
// - Calibrate on leaving mode change if enabled
// - In-progress flag high throughout calibration
// - Calibration lasts at least 168 sample periods
// - Transfers held off until calibration done
// - Resync ignores writes, reads return 80h
// - Format and config writes need mode change; config enable bits are written without it here
// - Legacy mode sends low byte first
// - Rate from playback format; capture format mode
// - Left channel precedes right channel
// - Four legacy encodings supported
// - Extended adds ADPCM and big endian; here both also work in legacy mode
// - Sixteen-bit two's complement code range
// - Eight-bit unsigned code range
// - Companding follows G.711
// - ADPCM four bits per sample
// - Upper base write loads current count
// - DMA needs enable set, PIO clear
// - Count down, after zero interrupt reload
// - Rollunder sets flag; status write clears
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defines.vh"

module cdc_host_seq
(
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// Playback sample in, 16-bit codes per channel
	input  wire        pb_valid_i,
	input  wire [15:0] pb_left_i,
	input  wire [15:0] pb_right_i,
	output wire        pb_ready_o,
	// Capture sample in, already encoded by the converter side
	input  wire        cp_valid_i,
	input  wire [15:0] cp_left_i,
	input  wire [15:0] cp_right_i,
	output wire        cp_ready_o,
	// Byte stream toward DMA, shared by both directions
	output reg  [7:0]  dma_byte_o,
	output reg         dma_byte_valid_o,
	output reg         dma_is_capture_o,
	input  wire        dma_byte_ready_i,
	// Status
	output wire        cal_busy_o,
	output wire        int_o
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_SEND = 2'h1;

	reg  [7:0]  index_q;
	reg  [7:0]  ratefmt_q;
	reg  [7:0]  capfmt_q;
	reg  [7:0]  ifcfg_q;
	reg         mode_ext_q;
	reg  [15:0] pbase_q;
	reg  [15:0] cbase_q;
	reg  [15:0] pcount_q;
	reg  [15:0] ccount_q;
	reg         pint_q;
	reg         cint_q;
	reg         cal_q;
	reg  [8:0]  cal_cnt_q;
	reg  [7:0]  resync_q;
	reg         ack_q;
	reg  [1:0]  st_q;
	reg  [2:0]  bidx_q;
	reg  [2:0]  blast_q;
	reg  [63:0] shreg_q;
	reg         dir_q;
	reg  [2:0]  ffmt_q;
	reg  [1:0]  psub_q;
	reg  [1:0]  csub_q;

	wire        fs_tick;
	wire        req;
	wire        wr;
	wire        busy;
	wire        mode_change_gate_bit;
	wire        gate_ok;
	wire        pb_dma;
	wire        cp_dma;
	wire        start_pb;
	wire        start_cp;
	wire [2:0]  pfmt;
	wire [2:0]  cfmt;
	wire        sample_done;
	wire        pb_roll;
	wire        cp_roll;
	wire        stat_wr;
	wire        byte_done;
	wire        is_wide;
	wire        is_adpcm;
	wire        fstereo;
	wire [2:0]  ffmt;
	wire [63:0] fbytes;
	wire [1:0]  sub_cur;

	assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr      = req & wb_we_i & wb_sel_i[0];
	assign wb_ack_o = ack_q;
	assign busy    = (resync_q != 8'h00);
	assign mode_change_gate_bit     = index_q[`CDC_IDX_MCE];
	assign gate_ok = mode_change_gate_bit & ~busy;
	assign stat_wr = wr & ~busy & (wb_adr_i == `CDC_A_STATUS);
	assign cal_busy_o = cal_q;

	cdc_fs_tick u_tick
	(
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.div_sel_i (ratefmt_q[`CDC_FMT_CFS_MSB:`CDC_FMT_CFS_LSB]),
		.tick_o    (fs_tick)
	);

	// Capture format follows playback register unless extended mode
	assign pfmt = ratefmt_q[`CDC_FMT_MSB:`CDC_FMT_LSB];
	assign cfmt = mode_ext_q ? capfmt_q[`CDC_FMT_MSB:`CDC_FMT_LSB]
	                         : pfmt;

	// Calibration gates DMA start; enable set and PIO clear required
	assign pb_dma = ifcfg_q[`CDC_CFG_PEN] & ~ifcfg_q[`CDC_CFG_PLAYBACK_PROGRAMMED_IO_SELECT]
	                & ~cal_q;
	assign cp_dma = ifcfg_q[`CDC_CFG_CEN] & ~ifcfg_q[`CDC_CFG_CAPTURE_PROGRAMMED_IO_SELECT]
	                & ~cal_q;
	assign start_pb = (st_q == S_IDLE) & pb_dma & pb_valid_i;
	assign start_cp = (st_q == S_IDLE) & cp_dma & cp_valid_i & ~start_pb;
	assign pb_ready_o = start_pb;
	assign cp_ready_o = start_cp;
	// Frame offered this cycle; capture stereo follows its own register
	// only in extended mode
	assign ffmt    = start_cp ? cfmt : pfmt;
	assign fstereo = (start_cp & mode_ext_q) ? capfmt_q[`CDC_FMT_STEREO]
	                 : ratefmt_q[`CDC_FMT_STEREO];
	assign fbytes  = fmt_bytes(ffmt, fstereo,
	                 start_cp ? cp_left_i : pb_left_i,
	                 start_cp ? cp_right_i : pb_right_i);
	assign byte_done = (st_q == S_SEND) & dma_byte_ready_i;
	assign is_wide   = (ffmt_q == `CDC_F_S16LE) | (ffmt_q == `CDC_F_S16BE);
	assign is_adpcm  = (ffmt_q == `CDC_F_ADPCM);
	assign sub_cur   = dir_q ? csub_q : psub_q;
	// Counters step per sample, not per frame: every 8-bit byte, every
	// second 16-bit byte, every fourth ADPCM byte
	assign sample_done = byte_done & (is_adpcm ? (sub_cur == 2'h3)
	                     : is_wide ? bidx_q[0] : 1'b1);
	assign pb_roll = sample_done & ~dir_q & (pcount_q == 16'h0000);
	assign cp_roll = sample_done & dir_q & (ccount_q == 16'h0000);
	assign int_o   = pint_q | cint_q;

	// Bus slave, one wait-free ack per request
	always @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h00000000;
		else if (req & busy)
			wb_dat_o <= {24'h000000, `CDC_BUSY_VAL};
		else if (req)
		begin
			case (wb_adr_i)
			`CDC_A_INDEX:    wb_dat_o <= {24'h000000, index_q};
			`CDC_A_RATEFMT:  wb_dat_o <= {24'h000000, ratefmt_q};
			`CDC_A_CAPFMT:   wb_dat_o <= {24'h000000, capfmt_q};
			`CDC_A_IFCFG:    wb_dat_o <= {24'h000000, ifcfg_q};
			`CDC_A_ERRSTAT:  wb_dat_o <= {26'h0000000, cal_q, 5'h00};
			`CDC_A_STATUS:   wb_dat_o <= {31'h00000000, int_o};
			`CDC_A_PBASE_LO: wb_dat_o <= {24'h000000, pbase_q[7:0]};
			`CDC_A_PBASE_HI: wb_dat_o <= {24'h000000, pbase_q[15:8]};
			`CDC_A_CBASE_LO: wb_dat_o <= {24'h000000, cbase_q[7:0]};
			`CDC_A_CBASE_HI: wb_dat_o <= {24'h000000, cbase_q[15:8]};
			`CDC_A_AFSTAT:   wb_dat_o <= {26'h0000000, cint_q, pint_q, 4'h0};
			`CDC_A_PCOUNT:   wb_dat_o <= {16'h0000, pcount_q};
			`CDC_A_CCOUNT:   wb_dat_o <= {16'h0000, ccount_q};
			`CDC_A_MODE:     wb_dat_o <= {25'h0000000, mode_ext_q, 6'h00};
			default:         wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// Configuration registers; all writes dropped during resync
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			index_q    <= `CDC_RST_INDEX;
			ratefmt_q  <= `CDC_RST_FMT;
			capfmt_q   <= `CDC_RST_FMT;
			ifcfg_q    <= `CDC_RST_CFG;
			mode_ext_q <= 1'b0;
			pbase_q    <= 16'h0000;
			cbase_q    <= 16'h0000;
		end
		else if (wr & ~busy)
		begin
			case (wb_adr_i)
			`CDC_A_INDEX: index_q <= wb_dat_i[7:0];
			`CDC_A_RATEFMT:
				if (gate_ok)
					ratefmt_q <= wb_dat_i[7:0];
			`CDC_A_CAPFMT:
				if (gate_ok)
					capfmt_q <= wb_dat_i[7:0];
			`CDC_A_IFCFG:
				if (gate_ok)
					ifcfg_q <= wb_dat_i[7:0];
				else
					ifcfg_q <= (ifcfg_q & ~`CDC_CFG_ENMASK)
					           | (wb_dat_i[7:0] & `CDC_CFG_ENMASK);
			`CDC_A_MODE: mode_ext_q <= wb_dat_i[`CDC_MODE_EXT];
			`CDC_A_PBASE_LO: pbase_q[7:0]  <= wb_dat_i[7:0];
			`CDC_A_PBASE_HI: pbase_q[15:8] <= wb_dat_i[7:0];
			`CDC_A_CBASE_LO: cbase_q[7:0]  <= wb_dat_i[7:0];
			`CDC_A_CBASE_HI: cbase_q[15:8] <= wb_dat_i[7:0];
			default: ;
			endcase
		end
	end

	// Resync window after a clock select change; counted in clocks
	always @(posedge clk_i)
	begin
		if (rst_i)
			resync_q <= 8'h00;
		else if (wr & ~busy & gate_ok & (wb_adr_i == `CDC_A_RATEFMT)
		         & (wb_dat_i[`CDC_FMT_CFS_MSB:`CDC_FMT_CSL]
		            != ratefmt_q[`CDC_FMT_CFS_MSB:`CDC_FMT_CSL]))
			resync_q <= `CDC_RESYNC_CYC;
		else if (busy)
			resync_q <= resync_q - 8'h01;
	end

	// Calibration: started by the write that clears mode change
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cal_q     <= 1'b0;
			cal_cnt_q <= 9'h000;
		end
		else if (wr & ~busy & (wb_adr_i == `CDC_A_INDEX) & mode_change_gate_bit
		         & ~wb_dat_i[`CDC_IDX_MCE] & ifcfg_q[`CDC_CFG_CALIBRATE_ON_EXIT_BIT])
		begin
			cal_q     <= 1'b1;
			cal_cnt_q <= 9'h000;
		end
		else if (cal_q & fs_tick)
		begin
			// Partial first period makes this a lower bound
			if (cal_cnt_q == `CDC_CAL_PERIODS)
				cal_q <= 1'b0;
			else
				cal_cnt_q <= cal_cnt_q + 9'h001;
		end
	end

	// Sample serialiser; bytes in shreg_q[63:56] go first
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q             <= S_IDLE;
			bidx_q           <= 3'h0;
			blast_q          <= 3'h0;
			shreg_q          <= 64'h0;
			dir_q            <= 1'b0;
			ffmt_q           <= 3'h0;
			dma_byte_o       <= 8'h00;
			dma_byte_valid_o <= 1'b0;
			dma_is_capture_o <= 1'b0;
		end
		else
		begin
			case (st_q)
			S_IDLE:
				if (start_pb | start_cp)
				begin
					dir_q            <= start_cp;
					dma_is_capture_o <= start_cp;
					st_q             <= S_SEND;
					bidx_q           <= 3'h0;
					dma_byte_valid_o <= 1'b1;
					ffmt_q           <= ffmt;
					shreg_q          <= fbytes;
					blast_q          <= nbytes(ffmt, fstereo);
					dma_byte_o       <= fbytes[63:56];
				end
			S_SEND:
				if (dma_byte_ready_i)
				begin
					if (bidx_q == blast_q)
					begin
						st_q             <= S_IDLE;
						dma_byte_valid_o <= 1'b0;
					end
					else
					begin
						bidx_q     <= bidx_q + 3'h1;
						shreg_q    <= {shreg_q[55:0], 8'h00};
						dma_byte_o <= shreg_q[55:48];
					end
				end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	// Packs one frame, left first codes pass through unchanged so
	// two's complement unsigned and G.711 keep
	// their meaning. ADPCM left nibble sits in the high four bits, right in the low.
	function [63:0] fmt_bytes;
		input [2:0]  f;
		input        stereo;
		input [15:0] l;
		input [15:0] r;
		begin
			case (f)
			`CDC_F_S16LE: fmt_bytes = {l[7:0], l[15:8], r[7:0], r[15:8],
			                           32'h0};
			`CDC_F_S16BE: fmt_bytes = {l, r, 32'h0};
			`CDC_F_ADPCM: fmt_bytes = {l[3:0], stereo ? r[3:0] : 4'h0,
			                           56'h0};
			default:      fmt_bytes = {l[7:0], r[7:0], 48'h0};
			endcase
		end
	endfunction

	// Index of the final byte of a frame
	function [2:0] nbytes;
		input [2:0] f;
		input       stereo;
		begin
			case (f)
			`CDC_F_S16LE: nbytes = stereo ? 3'h3 : 3'h1;
			`CDC_F_S16BE: nbytes = stereo ? 3'h3 : 3'h1;
			`CDC_F_ADPCM: nbytes = 3'h0;
			default:      nbytes = stereo ? 3'h1 : 3'h0;
			endcase
		end
	endfunction

	// Current counts: load on upper base write, count samples, reload
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pcount_q <= 16'h0000;
			ccount_q <= 16'h0000;
			psub_q   <= 2'h0;
			csub_q   <= 2'h0;
		end
		else
		begin
			// ADPCM byte phase; a base load below restarts it
			if (byte_done & ~dir_q & is_adpcm)
				psub_q <= psub_q + 2'h1;
			if (byte_done & dir_q & is_adpcm)
				csub_q <= csub_q + 2'h1;
			if (wr & ~busy & (wb_adr_i == `CDC_A_CBASE_HI))
				csub_q <= 2'h0;
			if (wr & ~busy & (wb_adr_i == `CDC_A_PBASE_HI))
			begin
				pcount_q <= {wb_dat_i[7:0], pbase_q[7:0]};
				psub_q   <= 2'h0;
			end
			else if (pb_roll)
				pcount_q <= pbase_q;
			else if (sample_done & ~dir_q)
				pcount_q <= pcount_q - 16'h0001;
			if (wr & ~busy & (wb_adr_i == `CDC_A_CBASE_HI))
				ccount_q <= {wb_dat_i[7:0], cbase_q[7:0]};
			else if (cp_roll)
				ccount_q <= cbase_q;
			else if (sample_done & dir_q)
				ccount_q <= ccount_q - 16'h0001;
		end
	end

	// Flags: set wins over any clear in the same cycle
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pint_q <= 1'b0;
			cint_q <= 1'b0;
		end
		else
		begin
			if (pb_roll)
				pint_q <= 1'b1;
			else if (stat_wr | (wr & ~busy & (wb_adr_i == `CDC_A_AFSTAT)
			         & ~wb_dat_i[`CDC_AF_PI]))
				pint_q <= 1'b0;
			if (cp_roll)
				cint_q <= 1'b1;
			else if (stat_wr | (wr & ~busy & (wb_adr_i == `CDC_A_AFSTAT)
			         & ~wb_dat_i[`CDC_AF_CI]))
				cint_q <= 1'b0;
		end
	end
endmodule // cdc_host_seq
`default_nettype wire

// ---- bench/chsdc_properties.sv ----
/*
 Checker for the codec host sequencing block: bus answers, calibration
 window and byte stream relations, seen from the top ports only.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module chsdc_props
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Bus
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_o,
	// Stream and status
	input  wire logic        pb_ready_o,
	input  wire logic        cp_ready_o,
	input  wire logic [7:0]  dma_byte_o,
	input  wire logic        dma_byte_valid_o,
	input  wire logic        dma_is_capture_o,
	input  wire logic        dma_byte_ready_i,
	input  wire logic        cal_busy_o,
	input  wire logic        int_o
);
	// Fastest sample tick is 625 clocks, so this is the shortest legal run
	localparam int CAL_MIN = 168 * 625;
	logic [16:0] cal_cnt_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	always @(posedge clk_i)
	begin
		if (rst_i || !cal_busy_o)
			cal_cnt_q <= 17'h00000;
		else
			cal_cnt_q <= cal_cnt_q + 17'h00001;
	end

	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_cal_cause: assert property ($rose(cal_busy_o) |->
		$past(wb_we_i && wb_stb_i && wb_adr_i == 6'h00 && !wb_dat_i[6]))
		else $error("calibration started without leaving mode change");
	a_cal_holds_off: assert property (cal_busy_o |->
		!pb_ready_o && !cp_ready_o)
		else $error("sample taken during calibration");
	a_cal_length: assert property ($fell(cal_busy_o) |->
		cal_cnt_q >= CAL_MIN)
		else $error("calibration too short");
	a_byte_hold: assert property (dma_byte_valid_o &&
		!dma_byte_ready_i |=> dma_byte_valid_o &&
		$stable(dma_byte_o) && $stable(dma_is_capture_o))
		else $error("byte changed while stalled");
	a_pb_first: assert property (pb_ready_o |=>
		dma_byte_valid_o && !dma_is_capture_o)
		else $error("playback frame not started");
	a_cp_first: assert property (cp_ready_o |=>
		dma_byte_valid_o && dma_is_capture_o)
		else $error("capture frame not started");
	a_int_cause: assert property ($rose(int_o) |->
		$past(dma_byte_valid_o && dma_byte_ready_i) ||
		$past(dma_byte_valid_o && dma_byte_ready_i, 2))
		else $error("interrupt without a finished frame");
	a_int_clear: assert property ($fell(int_o) |->
		$past(wb_cyc_i && wb_we_i))
		else $error("interrupt cleared without a write");
endmodule // chsdc_props

bind cdc_host_seq chsdc_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.pb_ready_o(pb_ready_o), .cp_ready_o(cp_ready_o),
	.dma_byte_o(dma_byte_o), .dma_byte_valid_o(dma_byte_valid_o),
	.dma_is_capture_o(dma_is_capture_o), .dma_byte_ready_i(dma_byte_ready_i),
	.cal_busy_o(cal_busy_o), .int_o(int_o));
`default_nettype wire

// ---- bench/chsdc_dma_host.sv ----
/*
 Model of the host DMA controller that takes the codec byte stream.
 Assumes the bench clock; slow mode stalls one cycle on every byte.
*/
`timescale 1ns/1ps
`default_nettype none
module chsdc_dma_host
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Stream side
	input  wire logic slow_i,
	input  wire logic byte_valid_i,
	output var  logic byte_ready_o
);
	// Slow mode answers only after seeing a byte, then drops again
	always @(posedge clk_i)
	begin
		if (rst_i)
			byte_ready_o <= 1'b0;
		else
			byte_ready_o <= slow_i ? (byte_valid_i & ~byte_ready_o) : 1'b1;
	end
endmodule // chsdc_dma_host
`default_nettype wire

// ---- bench/codec_host_sequencing_dma_count_test.sv ----
/*
 Self-checking bench for the codec host sequencing block: register bus,
 resync window, format byte order, counters and calibration.
 Assumes the DMA host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module codec_host_sequencing_dma_count_test;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic        pbv = 0, cpv = 0, slow = 0, flag = 0;
	logic [5:0]  adr = 0;
	logic [31:0] dat = 0, rdata;
	logic [15:0] pl = 0, pr = 0, cl = 0, cr = 0;
	logic [7:0]  q_exp[$], q_got[$];
	wire  [31:0] rd_w;
	wire  [7:0]  bbyte;
	wire         ack, pb_rdy, cp_rdy, bvalid, iscap, brdy, busy, irq;
	int          fail_count = 0, comparisons = 0, busy_n = 0, n, i;
	int          cnt[2] = '{1, 1};
	int          sub[2] = '{0, 0};
	int          fl[6] = '{0, 1, 2, 3, 5, 6};

	cdc_host_seq u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(dat), .wb_dat_o(rd_w), .wb_ack_o(ack), .pb_valid_i(pbv),
		.pb_left_i(pl), .pb_right_i(pr), .pb_ready_o(pb_rdy),
		.cp_valid_i(cpv), .cp_left_i(cl), .cp_right_i(cr),
		.cp_ready_o(cp_rdy), .dma_byte_o(bbyte), .dma_byte_valid_o(bvalid),
		.dma_is_capture_o(iscap), .dma_byte_ready_i(brdy),
		.cal_busy_o(busy), .int_o(irq));
	chsdc_dma_host u_host (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.byte_valid_i(bvalid), .byte_ready_o(brdy));

	initial forever #12.5 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		if (bvalid === 1'b1 && brdy === 1'b1)
			q_got.push_back(bbyte);
		if (busy === 1'b1)
			busy_n++;
	end

	task results;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack !== 1'b1 && k < 40);
		if (k >= 40)
		begin
			fail_count++;
			results;
		end
		rdata = rd_w;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk_i);
	endtask

	task rdc(input logic [5:0] a, input logic [31:0] exp, input string nm);
		wb(0, a, 0);
		chk(nm, rdata, exp);
	endtask

	task pushw(input logic [2:0] f, input logic [15:0] w);
		if (f == 3'h6)
			q_exp.push_back(w[15:8]);
		q_exp.push_back(w[7:0]);
		if (f == 3'h2)
			q_exp.push_back(w[15:8]);
	endtask

	// One frame through the stream, then the count and interrupt model
	task frame(input logic c, input logic [2:0] f, input logic st,
		input int lim);
		int k, s;
		logic [15:0] l, r;
		l = $urandom;
		r = $urandom;
		if (f == 3'h5)
			q_exp.push_back({l[3:0], r[3:0]});
		else
		begin
			pushw(f, l);
			if (st)
				pushw(f, r);
		end
		if (c)
		begin
			cpv <= 1;
			cl <= l;
			cr <= r;
		end
		else
		begin
			pbv <= 1;
			pl <= l;
			pr <= r;
		end
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while ((c ? cp_rdy : pb_rdy) !== 1'b1 && k < lim);
		pbv <= 0;
		cpv <= 0;
		if (k >= lim)
		begin
			fail_count++;
			results;
		end
		k = 0;
		while (q_got.size() < q_exp.size() && k < 40)
		begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 40)
		begin
			fail_count++;
			results;
		end
		// A few more edges so that a surplus byte would show
		repeat (4) @(posedge clk_i);
		while (q_exp.size() > 0)
			chk("stream byte", q_got.pop_front(), q_exp.pop_front());
		chk("extra bytes", q_got.size(), 0);
		q_got.delete();
		// Samples in this frame; ADPCM steps once per four bytes
		if (f == 3'h5)
		begin
			sub[c] = (sub[c] + 1) % 4;
			s = (sub[c] == 0) ? 1 : 0;
		end
		else
			s = st ? 2 : 1;
		repeat (s)
		begin
			if (cnt[c] == 0)
			begin
				cnt[c] = 1;
				flag = 1;
			end
			else
				cnt[c]--;
		end
		rdc(c ? 6'h30 : 6'h2c, cnt[c], "current count");
		chk("interrupt", irq, flag);
	endtask

	initial
	begin
		void'($urandom(62434));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		rdc(6'h00, 32'h40, "index reset");
		rdc(6'h0c, 32'h08, "config reset");
		// Rate change inside mode change, then poll out of resync
		wb(1, 6'h04, 32'h06);
		rdc(6'h00, 32'h80, "resync read");
		wb(1, 6'h08, 32'h55);
		n = 0;
		do
		begin
			wb(0, 6'h00, 0);
			n++;
		end
		while (rdata === 32'h80 && n < 100);
		chk("resync end", rdata, 32'h40);
		rdc(6'h08, 0, "write during resync");
		wb(1, 6'h34, 32'h40);
		// Base of one: two samples or eight ADPCM bytes
		wb(1, 6'h18, 1);
		wb(1, 6'h1c, 0);
		rdc(6'h2c, 1, "playback count load");
		wb(1, 6'h20, 1);
		wb(1, 6'h24, 0);
		rdc(6'h30, 1, "capture count load");
		wb(1, 6'h0c, 32'h0b);
		for (i = 0; i < 6; i++)
		begin
			wb(1, 6'h04, {fl[i][2:0], 1'b1, 4'h6});
			frame(0, fl[i][2:0], 1, 50);
		end
		wb(1, 6'h04, {3'h2, 1'b0, 4'h6});
		frame(0, 3'h2, 0, 50);
		slow <= 1;
		wb(1, 6'h08, {3'h6, 1'b1, 4'h0});
		frame(1, 3'h6, 1, 50);
		wb(1, 6'h34, 0);
		wb(1, 6'h04, {3'h2, 1'b1, 4'h6});
		frame(1, 3'h2, 1, 50);
		slow <= 0;
		// Both roll flags stand; a zero in the playback bit clears it alone
		rdc(6'h28, 32'h30, "roll flags");
		wb(1, 6'h28, 32'h20);
		rdc(6'h28, 32'h20, "flag zero write");
		chk("interrupt kept", irq, 1);
		wb(1, 6'h14, 32'h5a);
		flag = 0;
		chk("interrupt clear", irq, 0);
		wb(1, 6'h0c, 32'h4b);
		pbv <= 1;
		n = 0;
		repeat (30)
		begin
			@(posedge clk_i);
			if (pb_rdy === 1'b1)
				n++;
		end
		pbv <= 0;
		chk("pio holds dma", n, 0);
		wb(1, 6'h0c, 32'h0b);
		busy_n = 0;
		wb(1, 6'h00, 0);
		chk("calibration start", busy, 1);
		wb(0, 6'h10, 0);
		chk("calibration flag", rdata[5], 1);
		wb(1, 6'h04, 32'he0);
		rdc(6'h04, {3'h2, 1'b1, 4'h6}, "gated format");
		wb(1, 6'h0c, 32'h01);
		rdc(6'h0c, 32'h09, "enable exempt");
		frame(0, 3'h2, 1, 120000);
		chk("calibration length", busy_n >= 168 * 625, 1);
		wb(0, 6'h10, 0);
		chk("calibration done", rdata[5], 0);
		rdc(6'h3c, 0, "unmapped read");
		results;
	end
endmodule // codec_host_sequencing_dma_count_test
`default_nettype wire
